// File: common/kcc_pkg.sv
// Behaviour
// - Operating arrangement follows the initialization register only; it may change any time.
// - Each output is the nine window pixels times coefficients A to I, summed, plus the shifted cascade input while init bit 0 is clear.
// - Frame clear empties row buffers, multiplier input latches and output register.
// - Reset gives row length 1024, no delay, no ALU op, no rounding, unsigned.
// - Reset zeroes both coefficient banks and makes bank 0 active.
// - Nine coefficients are written one per write, A through I, stored in order.
// - Row length 3 with cascade bit clear gives a 9-tap FIR.
// - Init bit 0 set routes cascade input into the array as two pixel rows.
// - Input delay acts only on the direct pixel input, the bottom kernel row.
// - Pixel input is delayed by the clock count held in init bits 1 and 2.
// - Cascade input is shifted left by the amount in init bits 7 and 8.
// - One pixel is processed per clock, whatever the kernel or cascade depth.
// - With init bit 0 clear the shifted cascade input is added to the result.
// - The cascade shift is 0, 2, 4 or 8 positions left.
// - Select code 101 activates bank 0, code 110 activates bank 1, nothing stored.
// - A configuration write lands when chip select or load strobe returns high.
package kcc_pkg;
    localparam int unsigned PIX_W    = 8;
    localparam int unsigned CAS_W    = 16;
    localparam int unsigned OUT_W    = 20;
    localparam int unsigned CFG_W    = 10;
    localparam int unsigned SEL_W    = 3;
    localparam int unsigned INIT_W   = 9;
    localparam int unsigned TAPS     = 9;
    localparam int unsigned ROW_MAX  = 1024;
    localparam int unsigned IDX_W    = 4;

    // ****************************************************************
    // Register select codes
    // ****************************************************************
    localparam logic [2:0] SEL_ROWLEN = 3'h0;
    localparam logic [2:0] SEL_ALU    = 3'h1;
    localparam logic [2:0] SEL_BANK0  = 3'h2;
    localparam logic [2:0] SEL_BANK1  = 3'h3;
    localparam logic [2:0] SEL_INIT   = 3'h4;
    localparam logic [2:0] SEL_USE0   = 3'h5;
    localparam logic [2:0] SEL_USE1   = 3'h6;

    // ****************************************************************
    // Initialization register layout and reset values
    // ****************************************************************
    localparam int unsigned INIT_CASMODE = 0;
    localparam int unsigned INIT_DLY_LSB = 1;
    localparam int unsigned INIT_SIGNED  = 3;
    localparam int unsigned INIT_SH_LSB  = 7;
    localparam logic [8:0]  INIT_RST     = 9'h000;
    localparam logic [9:0]  ROWLEN_RST   = 10'h000;
    localparam logic [3:0]  LAST_TAP     = 4'h8;

    // Cascade shift codes and amounts
    localparam logic [1:0] SH_CODE_2 = 2'h1;
    localparam logic [1:0] SH_CODE_4 = 2'h2;
    localparam logic [1:0] SH_CODE_8 = 2'h3;
    localparam int unsigned SH_AMT_2 = 2;
    localparam int unsigned SH_AMT_4 = 4;
    localparam int unsigned SH_AMT_8 = 8;
endpackage : kcc_pkg

// File: hdl/kcc_row_mem.sv
`timescale 1ns/1ps
module kcc_row_mem #(
    parameter int unsigned W     = 16,
    parameter int unsigned DEPTH = 1024,
    parameter int unsigned AW    = 10
) (
    input  wire logic          clk_sys_i,
    input  wire logic          wr_en_i,
    input  wire logic [AW-1:0] wr_addr_i,
    input  wire logic [W-1:0]  wr_data_i,
    input  wire logic [AW-1:0] rd_addr_i,
    output logic      [W-1:0]  rd_data_o
);
    logic [W-1:0] mem_reg [0:DEPTH-1];
    logic [W-1:0] rd_data_reg;

    // No reset: contents are masked by the fill count after a clear
    always_ff @(posedge clk_sys_i) begin
        if (wr_en_i) begin
            mem_reg[wr_addr_i] <= wr_data_i;
        end
        rd_data_reg <= mem_reg[rd_addr_i];
    end

    assign rd_data_o = rd_data_reg;
endmodule : kcc_row_mem

// File: hdl/kcc_conv.sv
`timescale 1ns/1ps
module kcc_conv #(
    parameter int unsigned ROW_MAX = kcc_pkg::ROW_MAX
) (
    input  wire logic        clk_sys_i,
    input  wire logic        arst_n_i,
    input  wire logic        frame_clr_i,
    input  wire logic        cs_n_i,
    input  wire logic        load_strobe_n_i,
    input  wire logic [2:0]  reg_select_i,
    input  wire logic [9:0]  config_data_in_i,
    input  wire logic [7:0]  pixel_in_i,
    input  wire logic [15:0] cascade_in_i,
    output logic      [19:0] conv_out_o,
    output logic             active_bank_o
);
    localparam int unsigned AW = $clog2(ROW_MAX);
    localparam int unsigned SW = 2 + kcc_pkg::SEL_W + kcc_pkg::CFG_W;

    // ****************************************************************
    // Synchronisers for the asynchronous pins
    // ****************************************************************
    logic [SW-1:0] cfg_s1_reg;
    logic [SW-1:0] cfg_s2_reg;
    logic          frm_s1_reg;
    logic          frm_s2_reg;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_s1_reg <= {2'h3, {(SW-2){1'b0}}};
            cfg_s2_reg <= {2'h3, {(SW-2){1'b0}}};
            frm_s1_reg <= 1'b0;
            frm_s2_reg <= 1'b0;
        end else begin
            cfg_s1_reg <= {cs_n_i, load_strobe_n_i, reg_select_i, config_data_in_i};
            cfg_s2_reg <= cfg_s1_reg;
            frm_s1_reg <= frame_clr_i;
            frm_s2_reg <= frm_s1_reg;
        end
    end

    logic frame_q;
    logic strobe_now;
    assign frame_q    = frm_s2_reg;
    assign strobe_now = ~cfg_s2_reg[SW-1] & ~cfg_s2_reg[SW-2];

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    logic       strobe_reg,    strobe_next;
    logic [2:0] hold_sel_reg,  hold_sel_next;
    logic [9:0] hold_data_reg, hold_data_next;
    logic [9:0] row_len_reg,   row_len_next;
    logic [8:0] init_reg,      init_next;
    logic       bank_sel_reg,  bank_sel_next;
    logic [7:0] coef_reg  [0:1][0:8];
    logic [7:0] coef_next [0:1][0:8];
    logic [3:0] idx_reg   [0:1];
    logic [3:0] idx_next  [0:1];
    logic       wr_fire;

    // Write lands on the release of the combined strobe
    assign wr_fire = strobe_reg & ~strobe_now;

    always_comb begin
        strobe_next    = strobe_now;
        hold_sel_next  = strobe_now ? cfg_s2_reg[12:10] : hold_sel_reg;
        hold_data_next = strobe_now ? cfg_s2_reg[9:0] : hold_data_reg;
        row_len_next   = row_len_reg;
        init_next      = init_reg;
        bank_sel_next  = bank_sel_reg;
        coef_next      = coef_reg;
        idx_next       = idx_reg;
        if (wr_fire) begin
            case (hold_sel_reg)
                kcc_pkg::SEL_ROWLEN: row_len_next = hold_data_reg;
                kcc_pkg::SEL_INIT:   init_next = hold_data_reg[8:0];
                kcc_pkg::SEL_USE0:   bank_sel_next = 1'b0;
                kcc_pkg::SEL_USE1:   bank_sel_next = 1'b1;
                default:             ;
            endcase
            for (int b = 0; b < 2; b++) begin
                if (hold_sel_reg == (b == 0 ? kcc_pkg::SEL_BANK0 : kcc_pkg::SEL_BANK1)) begin
                    coef_next[b][idx_reg[b]] = hold_data_reg[7:0];
                    idx_next[b] = (idx_reg[b] == kcc_pkg::LAST_TAP) ? 4'h0 : idx_reg[b] + 4'h1;
                end else begin
                    // Any other write rewinds the load sequence to A
                    idx_next[b] = 4'h0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            strobe_reg    <= 1'b0;
            hold_sel_reg  <= 3'h0;
            hold_data_reg <= 10'h000;
            row_len_reg   <= kcc_pkg::ROWLEN_RST;
            init_reg      <= kcc_pkg::INIT_RST;
            bank_sel_reg  <= 1'b0;
            for (int b = 0; b < 2; b++) begin
                idx_reg[b] <= 4'h0;
                for (int k = 0; k < kcc_pkg::TAPS; k++) begin
                    coef_reg[b][k] <= 8'h00;
                end
            end
        end else begin
            strobe_reg    <= strobe_next;
            hold_sel_reg  <= hold_sel_next;
            hold_data_reg <= hold_data_next;
            row_len_reg   <= row_len_next;
            init_reg      <= init_next;
            bank_sel_reg  <= bank_sel_next;
            coef_reg      <= coef_next;
            idx_reg       <= idx_next;
        end
    end

    logic        cas_mode;
    logic        sgn;
    logic [1:0]  dly_sel;
    logic [1:0]  sh_sel;
    logic [10:0] row_len;
    assign cas_mode = init_reg[kcc_pkg::INIT_CASMODE];
    assign sgn      = init_reg[kcc_pkg::INIT_SIGNED];
    assign dly_sel  = init_reg[kcc_pkg::INIT_DLY_LSB +: 2];
    assign sh_sel   = init_reg[kcc_pkg::INIT_SH_LSB +: 2];
    // Zero in the row length register means the full buffer
    assign row_len  = (row_len_reg == 10'h000) ? 11'(ROW_MAX) : {1'b0, row_len_reg};

    // ****************************************************************
    // Pixel path: input delay, row buffers, window
    // ****************************************************************
    logic [7:0]    dly_reg [0:2];
    logic [7:0]    dly_next [0:2];
    logic [7:0]    pix_q_reg,  pix_q_next;
    logic [15:0]   cas_q_reg,  cas_q_next;
    logic [AW-1:0] ptr_reg,    ptr_next;
    logic [11:0]   fill_reg,   fill_next;
    logic [7:0]    win_reg  [0:2][0:2];
    logic [7:0]    win_next [0:2][0:2];
    logic [AW-1:0] rd_addr;
    logic [15:0]   rd_data;
    logic [7:0]    row_in [0:2];
    logic          ptr_last;

    // A row length cut below the pointer wraps at once instead of after the full buffer
    assign ptr_last = ({1'b0, ptr_reg} >= (row_len - 11'h001));
    assign rd_addr  = ptr_last ? '0 : ptr_reg + AW'(1);

    // Reading one slot ahead gives exactly one row of delay per lane
    kcc_row_mem #(
        .W     (16),
        .DEPTH (ROW_MAX),
        .AW    (AW)
    ) u_row_mem (
        .clk_sys_i (clk_sys_i),
        .wr_en_i   (1'b1),
        .wr_addr_i (ptr_reg),
        .wr_data_i ({rd_data[7:0], pix_q_reg}),
        .rd_addr_i (rd_addr),
        .rd_data_o (rd_data)
    );

    always_comb begin
        dly_next[0] = frame_q ? 8'h00 : pixel_in_i;
        dly_next[1] = frame_q ? 8'h00 : dly_reg[0];
        dly_next[2] = frame_q ? 8'h00 : dly_reg[1];
        // Only the direct pixel input is delayed
        pix_q_next  = (dly_sel == 2'h0) ? pixel_in_i : dly_reg[dly_sel - 2'h1];
        cas_q_next  = cascade_in_i;
        ptr_next    = ptr_last ? '0 : ptr_reg + AW'(1);
        fill_next   = (fill_reg >= {row_len, 1'b0}) ? fill_reg : fill_reg + 12'h001;
        // Stale buffer data after a clear reads as zero until overwritten
        row_in[2]   = pix_q_reg;
        row_in[1]   = cas_mode ? cas_q_reg[7:0] :
                      ((fill_reg >= {1'b0, row_len}) ? rd_data[7:0] : 8'h00);
        row_in[0]   = cas_mode ? cas_q_reg[15:8] :
                      ((fill_reg >= {row_len, 1'b0}) ? rd_data[15:8] : 8'h00);
        for (int r = 0; r < 3; r++) begin
            win_next[r][0] = row_in[r];
            win_next[r][1] = win_reg[r][0];
            win_next[r][2] = win_reg[r][1];
        end
        if (frame_q) begin
            pix_q_next = 8'h00;
            ptr_next   = '0;
            fill_next  = 12'h000;
            for (int r = 0; r < 3; r++) begin
                for (int c = 0; c < 3; c++) begin
                    win_next[r][c] = 8'h00;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pix_q_reg <= 8'h00;
            cas_q_reg <= 16'h0000;
            ptr_reg   <= '0;
            fill_reg  <= 12'h000;
            for (int r = 0; r < 3; r++) begin
                dly_reg[r] <= 8'h00;
                for (int c = 0; c < 3; c++) begin
                    win_reg[r][c] <= 8'h00;
                end
            end
        end else begin
            pix_q_reg <= pix_q_next;
            cas_q_reg <= cas_q_next;
            ptr_reg   <= ptr_next;
            fill_reg  <= fill_next;
            dly_reg   <= dly_next;
            win_reg   <= win_next;
        end
    end

    // ****************************************************************
    // Multiplier array, sum and cascade adder
    // ****************************************************************
    logic signed [17:0] prod [0:8];
    logic signed [19:0] acc;
    logic        [19:0] cas_ext;
    logic        [19:0] cas_sh;
    logic        [19:0] sum_reg, sum_next;
    logic        [19:0] out_reg, out_next;

    // Tap k: row k/3 top to bottom, A on the oldest column
    for (genvar k = 0; k < 9; k++) begin : g_tap
        logic [7:0] px;
        logic [7:0] cf;
        assign px = win_reg[k / 3][2 - (k % 3)];
        assign cf = coef_reg[bank_sel_reg][k];
        assign prod[k] = $signed({sgn & px[7], px}) * $signed({sgn & cf[7], cf});
    end

    always_comb begin
        acc = 20'sh00000;
        for (int k = 0; k < 9; k++) begin
            acc = acc + {{2{prod[k][17]}}, prod[k]};
        end
        cas_ext = {{4{sgn & cascade_in_i[15]}}, cascade_in_i};
        case (sh_sel)
            kcc_pkg::SH_CODE_2: cas_sh = cas_ext << kcc_pkg::SH_AMT_2;
            kcc_pkg::SH_CODE_4: cas_sh = cas_ext << kcc_pkg::SH_AMT_4;
            kcc_pkg::SH_CODE_8: cas_sh = cas_ext << kcc_pkg::SH_AMT_8;
            default:            cas_sh = cas_ext;
        endcase
        sum_next = frame_q ? 20'h00000 : acc;
        // Cascade data feed the array instead when bit 0 is set
        out_next = frame_q ? 20'h00000 : sum_reg + (cas_mode ? 20'h00000 : cas_sh);
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sum_reg <= 20'h00000;
            out_reg <= 20'h00000;
        end else begin
            sum_reg <= sum_next;
            out_reg <= out_next;
        end
    end

    assign conv_out_o    = out_reg;
    assign active_bank_o = bank_sel_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    use_bank1_a: assert property (
        wr_fire && hold_sel_reg == kcc_pkg::SEL_USE1 |=> bank_sel_reg && $stable(coef_reg[1][0]))
        else $error("bank 1 not made active");
    use_bank0_a: assert property (
        wr_fire && hold_sel_reg == kcc_pkg::SEL_USE0 |=> !active_bank_o)
        else $error("bank 0 not made active");
    coef_order_a: assert property (
        wr_fire && hold_sel_reg == kcc_pkg::SEL_BANK0 && idx_reg[0] == 4'h2
        |=> coef_reg[0][2] == $past(hold_data_reg[7:0]) && idx_reg[0] == 4'h3)
        else $error("coefficient C not stored in sequence");
    write_release_a: assert property (
        strobe_now ##1 !strobe_now && hold_sel_reg == kcc_pkg::SEL_INIT
        |=> init_reg == $past(hold_data_reg[8:0], 1))
        else $error("init write not latched on release");
    frame_clear_a: assert property (
        frame_q [*2] |=> conv_out_o == 20'h00000 && pix_q_reg == 8'h00)
        else $error("frame clear left data");
    cas_add_a: assert property (
        !frame_q && !cas_mode |=> conv_out_o == $past(sum_reg) + $past(cas_sh))
        else $error("cascade input not added");
    ext_route_a: assert property (
        cas_mode && !frame_q |=> win_reg[0][0] == $past(cas_q_reg[15:8])
                               && win_reg[1][0] == $past(cas_q_reg[7:0]))
        else $error("cascade rows not routed to array");
    dly3_a: assert property (
        (dly_sel == 2'h3 && !frame_q) [*5] |-> pix_q_reg == $past(pixel_in_i, 4))
        else $error("pixel delay of three wrong");
    shift8_a: assert property (
        sh_sel == kcc_pkg::SH_CODE_8 |-> cas_sh[7:0] == 8'h00
                                        && cas_sh[19:8] == cas_ext[11:0])
        else $error("cascade shift of eight wrong");
    ptr_wrap_a: assert property (
        ptr_last && !frame_q |=> ptr_reg == '0)
        else $error("row pointer did not wrap");

    ext_mode_c:   cover property (cas_mode && !frame_q ##1 !cas_mode);
    bank_swap_c:  cover property (wr_fire && hold_sel_reg == kcc_pkg::SEL_USE1);
    full_fill_c:  cover property (fill_reg >= {row_len, 1'b0} && !frame_q);
    fir_mode_c:   cover property (row_len == 11'h003 && !cas_mode && ptr_last);
endmodule : kcc_conv

// File: testbench/kcc_host_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Configuring processor on the far side of the setup port
// ****************************************************************
module kcc_host_model (
    input  wire logic       clk_sys_i,
    output logic            cs_n_o,
    output logic            load_strobe_n_o,
    output logic [2:0]      reg_select_o,
    output logic [9:0]      config_data_o
);
    initial begin
        cs_n_o          = 1'b1;
        load_strobe_n_o = 1'b1;
        reg_select_o    = 3'h7;
        config_data_o   = 10'h155;
    end

    // Low four edges and idle six: wider than the two-flop sync needs
    task automatic cfg_write(input logic [2:0] sel, input logic [9:0] data);
        @(posedge clk_sys_i);
        cs_n_o          <= 1'b0;
        load_strobe_n_o <= 1'b0;
        reg_select_o    <= sel;
        config_data_o   <= data;
        repeat (4) @(posedge clk_sys_i);
        cs_n_o          <= 1'b1;
        load_strobe_n_o <= 1'b1;
        // Bus is not valid once deselected, so it must not keep the value
        config_data_o   <= ~data;
        repeat (6) @(posedge clk_sys_i);
    endtask : cfg_write
endmodule : kcc_host_model

// File: testbench/tb_kernel3x3_convolver_cascade.sv
`timescale 1ns/1ps
module tb_kernel3x3_convolver_cascade;
    logic        clk_sys_i;
    logic        arst_n_i;
    logic        frame_clr;
    logic        cs_n;
    logic        load_strobe_n;
    logic [2:0]  reg_select;
    logic [9:0]  config_data;
    logic [7:0]  pixel_in;
    logic [15:0] cascade_in;
    logic [19:0] conv_out;
    logic        active_bank;
    int          n_mismatch;
    int          checks;
    logic [7:0]  pix_h [0:4095];
    logic [15:0] cas_h [0:4095];
    logic [7:0]  coef_b0 [0:8];
    logic [7:0]  coef_b1 [0:8];
    logic [7:0]  coef_m [0:8];
    logic [15:0] cas_const;

    initial clk_sys_i = 1'b0;
    always #4 clk_sys_i = ~clk_sys_i;

    kcc_conv #(.ROW_MAX(1024)) DUT (
        .clk_sys_i        (clk_sys_i),
        .arst_n_i         (arst_n_i),
        .frame_clr_i      (frame_clr),
        .cs_n_i           (cs_n),
        .load_strobe_n_i  (load_strobe_n),
        .reg_select_i     (reg_select),
        .config_data_in_i (config_data),
        .pixel_in_i       (pixel_in),
        .cascade_in_i     (cascade_in),
        .conv_out_o       (conv_out),
        .active_bank_o    (active_bank)
    );

    kcc_host_model u_host (
        .clk_sys_i       (clk_sys_i),
        .cs_n_o          (cs_n),
        .load_strobe_n_o (load_strobe_n),
        .reg_select_o    (reg_select),
        .config_data_o   (config_data)
    );

    // ****************************************************************
    // Checking and closing
    // ****************************************************************
    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic complete_run;
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    // Output seen after edge t: newest pixel is the one driven 4+d edges earlier
    function automatic logic [19:0] exp_at(input int t, input int d, input bit ext,
                                          input bit sgn, input int sh, input int L);
        int s;
        int a;
        logic [7:0] v;
        s = 0;
        for (int k = 0; k < 9; k++) begin
            a = t - 6 + k % 3;
            if (k / 3 == 2) v = pix_h[a - d];
            else if (ext) v = (k / 3 == 1) ? cas_h[a][7:0] : cas_h[a][15:8];
            else v = pix_h[a - d - L * (2 - k / 3)];
            s += sgn ? int'($signed(coef_m[k])) * int'($signed(v)) : int'(coef_m[k]) * int'(v);
        end
        a = (sh == 0) ? 0 : (sh == 1) ? kcc_pkg::SH_AMT_2 :
            (sh == 2) ? kcc_pkg::SH_AMT_4 : kcc_pkg::SH_AMT_8;
        if (!ext) s += int'(cas_h[t - 1]) << a;
        return s[19:0];
    endfunction : exp_at

    // Only outputs whose whole window was driven in this run are judged
    task automatic stream(input int d, input bit ext, input bit sgn, input int sh, input int L);
        int from;
        from = 12 + 2 * L + d;
        for (int t = 0; t < from + 6; t++) begin
            @(posedge clk_sys_i);
            pix_h[t] = 8'(t * 37 + 11);
            cas_h[t] = ext ? 16'(t * 1283 + 5) : cas_const;
            pixel_in   <= pix_h[t];
            cascade_in <= cas_h[t];
            @(negedge clk_sys_i);
            if (t >= from) chk("conv_out", exp_at(t, d, ext, sgn, sh, L), conv_out);
        end
    endtask : stream

    task automatic set_init(input logic e, input logic [1:0] d, input logic s, input logic [1:0] sh);
        u_host.cfg_write(kcc_pkg::SEL_INIT, {1'b0, sh, 3'h0, s, d, e});
    endtask : set_init

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic s_reset;
        repeat (2) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk("conv_out", 20'h00000, conv_out);
        chk("active_bank", 20'h00000, {19'h0, active_bank});
        @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        @(negedge clk_sys_i);
        chk("conv_out", 20'h00000, conv_out);
    endtask : s_reset

    task automatic s_default;
        for (int k = 0; k < 9; k++) coef_b0[k] = 8'(k + 1);
        for (int k = 0; k < 9; k++) u_host.cfg_write(kcc_pkg::SEL_BANK0, {2'h0, coef_b0[k]});
        coef_m = coef_b0;
        stream(0, 1'b0, 1'b0, 0, 1024);
    endtask : s_default

    task automatic s_fir_delay;
        u_host.cfg_write(kcc_pkg::SEL_ROWLEN, 10'h003);
        stream(0, 1'b0, 1'b0, 0, 3);
        for (int d = 1; d < 4; d++) begin
            set_init(1'b0, 2'(d), 1'b0, 2'h0);
            stream(d, 1'b0, 1'b0, 0, 3);
        end
    endtask : s_fir_delay

    task automatic s_cascade;
        for (int sh = 0; sh < 4; sh++) begin
            // Upstream sum wired from bits 2-17 or 4-19 for shifts 2 and 4, from bits 0-15 for no shift and shift 8
            cas_const = 16'(20'h9a5c3 >> ((sh == 1) ? 2 : (sh == 2) ? 4 : 0));
            set_init(1'b0, 2'h0, 1'b0, 2'(sh));
            stream(0, 1'b0, 1'b0, sh, 3);
        end
        cas_const = 16'h0000;
    endtask : s_cascade

    task automatic s_signed_ext;
        for (int k = 0; k < 9; k++) coef_b0[k] = 8'(200 + k * 7);
        for (int k = 0; k < 9; k++) u_host.cfg_write(kcc_pkg::SEL_BANK0, {2'h0, coef_b0[k]});
        coef_m = coef_b0;
        set_init(1'b0, 2'h0, 1'b1, 2'h0);
        stream(0, 1'b0, 1'b1, 0, 3);
        set_init(1'b1, 2'h1, 1'b0, 2'h0);
        stream(1, 1'b1, 1'b0, 0, 0);
        set_init(1'b0, 2'h0, 1'b0, 2'h0);
    endtask : s_signed_ext

    task automatic s_banks;
        // Bank 1 holds the first device's share of a split kernel
        for (int k = 0; k < 9; k++) begin
            coef_b1[k] = (k < 3) ? coef_b0[k + 3] : (k < 6) ? 8'h00 : coef_b0[k];
        end
        for (int k = 0; k < 9; k++) u_host.cfg_write(kcc_pkg::SEL_BANK1, {2'h0, coef_b1[k]});
        stream(0, 1'b0, 1'b0, 0, 3);
        u_host.cfg_write(kcc_pkg::SEL_USE1, 10'h3ff);
        chk("active_bank", 20'h00001, {19'h0, active_bank});
        u_host.cfg_write(kcc_pkg::SEL_ALU, 10'h0ff);
        u_host.cfg_write(3'h7, 10'h2aa);
        coef_m = coef_b1;
        chk("active_bank", 20'h00001, {19'h0, active_bank});
        stream(0, 1'b0, 1'b0, 0, 3);
        u_host.cfg_write(kcc_pkg::SEL_USE0, 10'h000);
        chk("active_bank", 20'h00000, {19'h0, active_bank});
        coef_m = coef_b0;
        stream(0, 1'b0, 1'b0, 0, 3);
    endtask : s_banks

    task automatic s_frame;
        @(posedge clk_sys_i);
        frame_clr <= 1'b1;
        repeat (6) @(negedge clk_sys_i);
        chk("conv_out", 20'h00000, conv_out);
        @(posedge clk_sys_i);
        frame_clr <= 1'b0;
        stream(0, 1'b0, 1'b0, 0, 3);
    endtask : s_frame

    initial begin
        arst_n_i   = 1'b0;
        frame_clr  = 1'b0;
        pixel_in   = 8'h00;
        cascade_in = 16'h0000;
        cas_const  = 16'h0000;
        n_mismatch = 0;
        checks     = 0;
        s_reset();
        s_default();
        s_fir_delay();
        s_cascade();
        s_signed_ext();
        s_banks();
        s_frame();
        complete_run();
    end

    // About 2900 cycles expected; the limit leaves wide margin
    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end
endmodule : tb_kernel3x3_convolver_cascade
